// ===== logic/irq_ctrl_regs.svh
/*
  Constants for the prioritized interrupt controller: field positions, reset values, counts.
  Assumes it is included by bare name from the package and the design modules.
*/
// Operation
// - Each source keeps a pending flag that its request sets and only a software write clears.
// - Each source has its own enable bit written by software.
// - Each user source has a programmable 3-bit priority choosing one of eight levels.
// - A selected interrupt latches its 8-bit vector number and 4-bit new level into a latch.
// - The latched new level equals the programmed priority of the selected source.
// - Source positions follow vector order, source 0 is vector 8 at bit 0 and priority bits 2:0.
// - The CPU level sits in status bits 7:5, readable and writable by software.
// - A read-only fourth level bit in the core control register completes the current level.
// - Global control register a holds nesting disable and the trap control and status flags.
// - Global control register b holds external request edge polarity and the global enable.
// - Global control register c holds the DMA trap and loop-stack overflow trap flags.
// - Global control register d holds the software hard trap flag.
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH
`define VEC_BASE 8'h08
`define PRIO_W 3
`define LEVEL_W 4
`define VEC_W 8
`define STATUS_LEVEL_LSB 5
`define STATUS_LEVEL_MSB 7
`define GCA_NESTING_DIS 15
`define GCA_TRAP_LSB 0
`define GCA_TRAP_W 5
`define GCB_GIE 15
`define GCC_DMA_TRAP 5
`define GCC_LOOP_TRAP 4
`define GCD_SOFT_HARD_TRAP 0
`define GCTRL_RESET 16'h0000
`define GCB_RESET 16'h8000
`define N_SOURCES_DEF 16
`endif

// ===== logic/irq_ctrl_pkg.sv
/*
  Types for the prioritized interrupt controller.
  Assumes irq_ctrl_regs.svh is on the include path.
*/
`include "irq_ctrl_regs.svh"
package irq_ctrl_pkg;
  // winner of the arbitration, as seen by the cpu
  typedef struct packed {
    logic [`VEC_W-1:0] vector_number_field;
    logic [`LEVEL_W-1:0] new_level_field;
  } vector_level_t;
  // software write to a 16-bit control word
  typedef struct packed {
    logic we;
    logic [15:0] data;
  } word_write_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PRESENT = 3'b010,
    ST_ACK = 3'b100
  } irq_state_t;
endpackage : irq_ctrl_pkg

// ===== logic/irq_source_bank.sv
/*
  Per-source pending, enable and priority storage.
  Assumes request pulses and software strobes are synchronous to clk.
*/
`include "irq_ctrl_regs.svh"
module irq_source_bank #(
  parameter int N = `N_SOURCES_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request sources
  input wire logic [N-1:0] request,
  // software access
  input wire logic [N-1:0] flag_clear,
  input wire logic enable_we,
  input wire logic [N-1:0] enable_wdata,
  input wire logic prio_we,
  input wire logic [N*`PRIO_W-1:0] prio_wdata,
  // stored state
  output logic [N-1:0] pending_flag_regs,
  output logic [N-1:0] source_enable_regs,
  output logic [N*`PRIO_W-1:0] source_priority_regs
);
  // flags: a request in the clearing cycle wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      pending_flag_regs <= '0;
    end else begin
      pending_flag_regs <= (pending_flag_regs & ~flag_clear) | request;
    end
  end
  // per-source enables
  always_ff @(posedge clk) begin
    if (rst) begin
      source_enable_regs <= '0;
    end else if (enable_we) begin
      source_enable_regs <= enable_wdata;
    end
  end
  // priorities, three bits per source in vector order
  always_ff @(posedge clk) begin
    if (rst) begin
      source_priority_regs <= '0;
    end else if (prio_we) begin
      source_priority_regs <= prio_wdata;
    end
  end
  property p_flag_sticky;
    @(posedge clk) disable iff (rst)
    request[0] |=> pending_flag_regs[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("pending flag not set");
  property p_flag_hold;
    @(posedge clk) disable iff (rst)
    pending_flag_regs[0] && !flag_clear[0] |=> pending_flag_regs[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("pending flag lost without clear");
endmodule : irq_source_bank

// ===== logic/irq_arbiter.sv
/*
  Combinational arbiter: highest priority eligible source, lowest index on ties.
  Assumes inputs come from registers on the same clock.
*/
`include "irq_ctrl_regs.svh"
module irq_arbiter #(
  parameter int N = `N_SOURCES_DEF
) (
  // candidate state
  input wire logic [N-1:0] eligible,
  input wire logic [N*`PRIO_W-1:0] prio,
  input wire logic [`LEVEL_W-1:0] cpu_level,
  // result
  output logic found,
  output logic [`VEC_W-1:0] win_index,
  output logic [`PRIO_W-1:0] win_prio
);
  // strict compare keeps lower index on equal priority
  always_comb begin
    found = 1'b0;
    win_index = '0;
    win_prio = '0;
    for (int i = 0; i < N; i++) begin
      if (eligible[i] && ({1'b0, prio[i*`PRIO_W +: `PRIO_W]} > cpu_level) &&
          (!found || prio[i*`PRIO_W +: `PRIO_W] > win_prio)) begin
        found = 1'b1;
        win_index = 8'(i);
        win_prio = prio[i*`PRIO_W +: `PRIO_W];
      end
    end
  end
endmodule : irq_arbiter

// ===== logic/irq_controller.sv
/*
  Prioritized vectored interrupt controller top: global control words, cpu level,
  arbitration and the vector/level latch.
  Assumes the cpu acknowledges a presented request with irq_ack and writes
  its status level through status_wr; external requests arrive as pins.
*/
`include "irq_ctrl_regs.svh"
module irq_controller #(
  parameter int N = `N_SOURCES_DEF,
  parameter int N_EXT = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // peripheral requests (same clock) and external pins
  input wire logic [N-1:0] periph_request,
  input wire logic [N_EXT-1:0] ext_pin,
  // trap events and the level msb from the core
  input wire logic [`GCA_TRAP_W-1:0] trap_event,
  input wire logic dma_trap_event,
  input wire logic loop_trap_event,
  input wire logic soft_trap_event,
  input wire logic cpu_priority_msb_set,
  // software access to source storage
  input wire logic [N-1:0] flag_clear,
  input wire logic enable_we,
  input wire logic [N-1:0] enable_wdata,
  input wire logic prio_we,
  input wire logic [N*`PRIO_W-1:0] prio_wdata,
  // software access to control words
  input irq_ctrl_pkg::word_write_t gca_wr,
  input irq_ctrl_pkg::word_write_t gcb_wr,
  input irq_ctrl_pkg::word_write_t gcc_wr,
  input irq_ctrl_pkg::word_write_t gcd_wr,
  input irq_ctrl_pkg::word_write_t status_wr,
  // cpu handshake
  input wire logic irq_ack,
  output logic irq_req,
  // readback
  output logic [N-1:0] pending_flag_regs,
  output logic [N-1:0] source_enable_regs,
  output logic [N*`PRIO_W-1:0] source_priority_regs,
  output logic [15:0] global_ctrl_reg_a,
  output logic [15:0] global_ctrl_reg_b,
  output logic [15:0] global_ctrl_reg_c,
  output logic [15:0] global_ctrl_reg_d,
  output logic [7:0] cpu_status_reg,
  output logic [15:0] core_control_reg,
  output irq_ctrl_pkg::vector_level_t vector_level_latch,
  output logic [`LEVEL_W-1:0] cpu_priority_level
);
  irq_ctrl_pkg::irq_state_t state_q;
  logic [N_EXT-1:0] s1_q, s2_q, s3_q, ext_level_q, ext_level_d;
  logic [N-1:0] request, eligible;
  logic [`PRIO_W-1:0] status_level_q;
  logic cpu_priority_msb_q;
  logic found;
  logic [`VEC_W-1:0] win_index;
  logic [`PRIO_W-1:0] win_prio;
  logic [`GCA_TRAP_W-1:0] trap_clr;

  // pin synchroniser, change taken when stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      ext_level_q <= '0;
    end else begin
      s1_q <= ext_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      ext_level_q <= ext_level_d;
    end
  end
  // filtered level and edge select per external line
  always_comb begin
    ext_level_d = ext_level_q;
    request = periph_request;
    for (int e = 0; e < N_EXT; e++) begin
      if (s2_q[e] == s3_q[e]) begin
        ext_level_d[e] = s3_q[e];
      end
      // polarity bit e of control word b: 0 rising, 1 falling
      if (global_ctrl_reg_b[e]) begin
        request[e] = request[e] | (ext_level_q[e] & ~ext_level_d[e]);
      end else begin
        request[e] = request[e] | (~ext_level_q[e] & ext_level_d[e]);
      end
    end
  end

  irq_source_bank #(.N(N)) u_bank (
    .clk(clk),
    .rst(rst),
    .request(request),
    .flag_clear(flag_clear),
    .enable_we(enable_we),
    .enable_wdata(enable_wdata),
    .prio_we(prio_we),
    .prio_wdata(prio_wdata),
    .pending_flag_regs(pending_flag_regs),
    .source_enable_regs(source_enable_regs),
    .source_priority_regs(source_priority_regs)
  );

  // eligible only with flag, enable and global enable
  assign eligible = (global_ctrl_reg_b[`GCB_GIE] && state_q == irq_ctrl_pkg::ST_IDLE) ?
                    (pending_flag_regs & source_enable_regs) : '0;

  irq_arbiter #(.N(N)) u_arb (
    .eligible(eligible),
    .prio(source_priority_regs),
    .cpu_level(cpu_priority_level),
    .found(found),
    .win_index(win_index),
    .win_prio(win_prio)
  );

  // trap flags in word a: write a one to clear, event wins
  assign trap_clr = gca_wr.we ? gca_wr.data[`GCA_TRAP_LSB +: `GCA_TRAP_W] : '0;
  always_ff @(posedge clk) begin
    if (rst) begin
      global_ctrl_reg_a <= `GCTRL_RESET;
    end else begin
      if (gca_wr.we) begin
        global_ctrl_reg_a[`GCA_NESTING_DIS] <= gca_wr.data[`GCA_NESTING_DIS];
      end
      global_ctrl_reg_a[`GCA_TRAP_LSB +: `GCA_TRAP_W] <=
        (global_ctrl_reg_a[`GCA_TRAP_LSB +: `GCA_TRAP_W] & ~trap_clr) | trap_event;
    end
  end
  // word b is plain storage: enable and polarity
  always_ff @(posedge clk) begin
    if (rst) begin
      global_ctrl_reg_b <= `GCB_RESET;
    end else if (gcb_wr.we) begin
      global_ctrl_reg_b <= gcb_wr.data;
    end
  end
  // sticky flag: a set in the clearing cycle wins, so no event is lost
  function automatic logic sticky_next(input logic set_ev, input logic cur, input logic clr);
    sticky_next = set_ev | (cur & ~clr);
  endfunction : sticky_next
  // word c: dma and loop-stack trap flags, clear by writing zero
  always_ff @(posedge clk) begin
    if (rst) begin
      global_ctrl_reg_c <= `GCTRL_RESET;
    end else begin
      global_ctrl_reg_c[`GCC_DMA_TRAP] <= sticky_next(dma_trap_event,
        global_ctrl_reg_c[`GCC_DMA_TRAP], gcc_wr.we & ~gcc_wr.data[`GCC_DMA_TRAP]);
      global_ctrl_reg_c[`GCC_LOOP_TRAP] <= sticky_next(loop_trap_event,
        global_ctrl_reg_c[`GCC_LOOP_TRAP], gcc_wr.we & ~gcc_wr.data[`GCC_LOOP_TRAP]);
    end
  end
  // word d: software hard trap flag
  always_ff @(posedge clk) begin
    if (rst) begin
      global_ctrl_reg_d <= `GCTRL_RESET;
    end else begin
      global_ctrl_reg_d[`GCD_SOFT_HARD_TRAP] <= sticky_next(soft_trap_event,
        global_ctrl_reg_d[`GCD_SOFT_HARD_TRAP],
        gcd_wr.we & ~gcd_wr.data[`GCD_SOFT_HARD_TRAP]);
    end
  end

  // cpu level: software writes bits 7:5, ack loads the new level
  always_ff @(posedge clk) begin
    if (rst) begin
      status_level_q <= '0;
    end else if (state_q == irq_ctrl_pkg::ST_PRESENT && irq_ack) begin
      status_level_q <= vector_level_latch.new_level_field[`PRIO_W-1:0];
    end else if (status_wr.we) begin
      status_level_q <= status_wr.data[`STATUS_LEVEL_MSB:`STATUS_LEVEL_LSB];
    end
  end
  // msb is core owned, no software path
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_priority_msb_q <= 1'b0;
    end else begin
      cpu_priority_msb_q <= cpu_priority_msb_set;
    end
  end
  assign cpu_priority_level = {cpu_priority_msb_q, status_level_q};
  assign cpu_status_reg = {status_level_q, 5'h00};
  assign core_control_reg = {12'h000, cpu_priority_msb_q, 3'h0};

  // presentation sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= irq_ctrl_pkg::ST_IDLE;
    end else begin
      case (state_q)
        irq_ctrl_pkg::ST_IDLE: begin
          if (found) begin
            state_q <= irq_ctrl_pkg::ST_PRESENT;
          end
        end
        irq_ctrl_pkg::ST_PRESENT: begin
          if (irq_ack) begin
            state_q <= irq_ctrl_pkg::ST_ACK;
          end
        end
        irq_ctrl_pkg::ST_ACK: state_q <= irq_ctrl_pkg::ST_IDLE;
        default: state_q <= irq_ctrl_pkg::ST_IDLE;
      endcase
    end
  end
  // latch the winner as vector and level
  always_ff @(posedge clk) begin
    if (rst) begin
      vector_level_latch <= '0;
    end else if (state_q == irq_ctrl_pkg::ST_IDLE && found) begin
      vector_level_latch.vector_number_field <= `VEC_BASE + win_index;
      vector_level_latch.new_level_field <= {1'b0, win_prio};
    end
  end
  assign irq_req = (state_q == irq_ctrl_pkg::ST_PRESENT);

  // checks on latch, presentation, cpu level and control words
  property p_latch_level;
    @(posedge clk) disable iff (rst)
    state_q == irq_ctrl_pkg::ST_IDLE && found |=>
    vector_level_latch.new_level_field == {1'b0, $past(win_prio)};
  endproperty
  a_latch_level: assert property (p_latch_level)
    else $error("latched level differs from winner priority");
  property p_latch_vector;
    @(posedge clk) disable iff (rst)
    state_q == irq_ctrl_pkg::ST_IDLE && found |=>
    vector_level_latch.vector_number_field == `VEC_BASE + $past(win_index);
  endproperty
  a_latch_vector: assert property (p_latch_vector)
    else $error("vector number not base plus index");
  property p_latch_hold;
    @(posedge clk) disable iff (rst)
    state_q != irq_ctrl_pkg::ST_IDLE |=> $stable(vector_level_latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch changed while a request is presented");
  property p_req_needs_gie;
    @(posedge clk) disable iff (rst)
    $rose(irq_req) |-> $past(global_ctrl_reg_b[`GCB_GIE]);
  endproperty
  a_req_needs_gie: assert property (p_req_needs_gie)
    else $error("request without global enable");
  property p_req_above_level;
    @(posedge clk) disable iff (rst)
    $rose(irq_req) |-> vector_level_latch.new_level_field > $past(cpu_priority_level);
  endproperty
  a_req_above_level: assert property (p_req_above_level)
    else $error("request not above cpu level");
  property p_req_holds;
    @(posedge clk) disable iff (rst)
    irq_req && !irq_ack |=> irq_req;
  endproperty
  a_req_holds: assert property (p_req_holds)
    else $error("request dropped before acknowledge");
  property p_req_drops;
    @(posedge clk) disable iff (rst)
    irq_req && irq_ack |=> !irq_req;
  endproperty
  a_req_drops: assert property (p_req_drops)
    else $error("request still presented after acknowledge");
  property p_state_onehot;
    @(posedge clk) disable iff (rst)
    $onehot(state_q);
  endproperty
  a_state_onehot: assert property (p_state_onehot)
    else $error("sequencer state not one-hot");
  property p_ack_level;
    @(posedge clk) disable iff (rst)
    state_q == irq_ctrl_pkg::ST_PRESENT && irq_ack |=>
    cpu_priority_level[`PRIO_W-1:0] == $past(vector_level_latch.new_level_field[`PRIO_W-1:0]);
  endproperty
  a_ack_level: assert property (p_ack_level)
    else $error("cpu level not loaded from latch on acknowledge");
  property p_status_write;
    @(posedge clk) disable iff (rst)
    status_wr.we && !(state_q == irq_ctrl_pkg::ST_PRESENT && irq_ack) |=>
    cpu_status_reg[7:5] == $past(status_wr.data[7:5]);
  endproperty
  a_status_write: assert property (p_status_write)
    else $error("status level write lost");
  property p_msb_readonly;
    @(posedge clk) disable iff (rst)
    status_wr.we && !cpu_priority_msb_set |=> !core_control_reg[3];
  endproperty
  a_msb_readonly: assert property (p_msb_readonly)
    else $error("level msb moved by software");
  property p_nesting_write;
    @(posedge clk) disable iff (rst)
    gca_wr.we |=> global_ctrl_reg_a[`GCA_NESTING_DIS] == $past(gca_wr.data[`GCA_NESTING_DIS]);
  endproperty
  a_nesting_write: assert property (p_nesting_write)
    else $error("nesting disable write lost");
  property p_trap_set;
    @(posedge clk) disable iff (rst)
    trap_event != '0 |=>
    (global_ctrl_reg_a[`GCA_TRAP_LSB +: `GCA_TRAP_W] & $past(trap_event)) == $past(trap_event);
  endproperty
  a_trap_set: assert property (p_trap_set)
    else $error("trap flag not set by event");
  property p_gcb_write;
    @(posedge clk) disable iff (rst)
    gcb_wr.we |=> global_ctrl_reg_b == $past(gcb_wr.data);
  endproperty
  a_gcb_write: assert property (p_gcb_write)
    else $error("control word b write lost");
  property p_soft_trap;
    @(posedge clk) disable iff (rst)
    soft_trap_event |=> global_ctrl_reg_d[`GCD_SOFT_HARD_TRAP];
  endproperty
  a_soft_trap: assert property (p_soft_trap)
    else $error("soft hard trap flag not set");
  property p_dma_trap;
    @(posedge clk) disable iff (rst)
    dma_trap_event ##1 !(gcc_wr.we && !gcc_wr.data[`GCC_DMA_TRAP]) |->
    global_ctrl_reg_c[`GCC_DMA_TRAP][*2];
  endproperty
  a_dma_trap: assert property (p_dma_trap)
    else $error("dma trap flag not sticky");
  property p_loop_trap;
    @(posedge clk) disable iff (rst)
    loop_trap_event |=> global_ctrl_reg_c[`GCC_LOOP_TRAP];
  endproperty
  a_loop_trap: assert property (p_loop_trap)
    else $error("loop-stack trap flag not set");
endmodule : irq_controller

// ===== testbench/cpu_ack_model.sv
/*
  Behavioural model of the cpu core side: accepts a presented request after a delay.
  Assumes irq_req and rst are synchronous to clk, as the controller drives them.
*/
module cpu_ack_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // handshake
  input wire logic irq_req,
  input wire logic [3:0] ack_delay,
  output logic irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  // one-cycle ack pulse, so the controller never sees a stale accept
  always_ff @(posedge clk) begin
    if (rst || irq_ack) begin
      irq_ack <= 1'b0;
      wait_q <= 4'h0;
    end else if (irq_req) begin
      if (wait_q == ack_delay) begin
        irq_ack <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : cpu_ack_model

// ===== testbench/testbench.sv
/*
  Self-checking bench for the interrupt controller: source setup, arbitration, cpu level,
  control words and traps. Assumes a 20 MHz clock and the cpu model on the ack line.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] periph_request = '0;
  logic [0:0] ext_pin = '0;
  logic [4:0] trap_event = '0;
  logic dma_trap_event = 1'b0;
  logic loop_trap_event = 1'b0;
  logic soft_trap_event = 1'b0;
  logic msb_set = 1'b0;
  logic [15:0] flag_clear = '0;
  logic enable_we = 1'b0;
  logic [15:0] enable_wdata = '0;
  logic prio_we = 1'b0;
  logic [47:0] prio_wdata = '0;
  irq_ctrl_pkg::word_write_t gca_wr = '0, gcb_wr = '0, gcc_wr = '0, gcd_wr = '0, status_wr = '0;
  logic irq_ack, irq_req;
  logic [3:0] ack_delay = 4'h0;
  logic [15:0] pend, en, gca, gcb, gcc, gcd, core_ctrl;
  logic [47:0] prio;
  logic [7:0] status;
  irq_ctrl_pkg::vector_level_t latch;
  logic [3:0] level;
  int fails = 0;
  int n_checks = 0;
  // 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end
  irq_controller #(.N(16), .N_EXT(1)) i_dut (.clk(clk), .rst(rst),
    .periph_request(periph_request), .ext_pin(ext_pin), .trap_event(trap_event),
    .dma_trap_event(dma_trap_event), .loop_trap_event(loop_trap_event),
    .soft_trap_event(soft_trap_event), .cpu_priority_msb_set(msb_set),
    .flag_clear(flag_clear), .enable_we(enable_we), .enable_wdata(enable_wdata),
    .prio_we(prio_we), .prio_wdata(prio_wdata), .gca_wr(gca_wr), .gcb_wr(gcb_wr),
    .gcc_wr(gcc_wr), .gcd_wr(gcd_wr), .status_wr(status_wr), .irq_ack(irq_ack),
    .irq_req(irq_req), .pending_flag_regs(pend), .source_enable_regs(en),
    .source_priority_regs(prio), .global_ctrl_reg_a(gca), .global_ctrl_reg_b(gcb),
    .global_ctrl_reg_c(gcc), .global_ctrl_reg_d(gcd), .cpu_status_reg(status),
    .core_control_reg(core_ctrl), .vector_level_latch(latch), .cpu_priority_level(level));
  cpu_ack_model i_cpu (.clk(clk), .rst(rst), .irq_req(irq_req), .ack_delay(ack_delay),
    .irq_ack(irq_ack));
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one control word write strobe; sel 0..3 words a..d, 4 status
  task automatic wr(input int sel, input logic [15:0] d);
    @(posedge clk);
    case (sel)
      0: gca_wr <= '{1'b1, d};
      1: gcb_wr <= '{1'b1, d};
      2: gcc_wr <= '{1'b1, d};
      3: gcd_wr <= '{1'b1, d};
      default: status_wr <= '{1'b1, d};
    endcase
    @(posedge clk);
    {gca_wr, gcb_wr, gcc_wr, gcd_wr, status_wr} <= '0;
    #1;
  endtask : wr
  // one-cycle request pulse (rq) or flag clear pulse (cl)
  task automatic pulse(input logic [15:0] rq, input logic [15:0] cl);
    @(posedge clk);
    periph_request <= rq;
    flag_clear <= cl;
    @(posedge clk);
    periph_request <= '0;
    flag_clear <= '0;
    #1;
  endtask : pulse
  task automatic src_cfg(input logic [15:0] e, input logic [47:0] p);
    @(posedge clk);
    {enable_we, enable_wdata, prio_we, prio_wdata} <= {1'b1, e, 1'b1, p};
    @(posedge clk);
    {enable_we, prio_we} <= 2'b00;
    #1;
  endtask : src_cfg
  // bounded wait for a presented request, then the latch is compared
  task automatic expect_req(input logic [11:0] vl);
    int i;
    for (i = 0; i < 10 && irq_req !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("irq_req", 1, irq_req);
    chk("vector_level_latch", vl, latch);
    for (i = 0; i < 12 && irq_req !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask : expect_req
  task automatic no_req(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      chk("irq_req idle", 0, irq_req);
    end
  endtask : no_req
  // watchdog, far beyond the roughly 140 cycles of the sequence
  initial begin
    repeat (4000) @(posedge clk);
    fails++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("gcb reset", 16'h8000, gcb);
    chk("gca gcc gcd reset", 0, {gca, gcc, gcd});
    chk("latch reset", 0, {latch, pend, irq_req});
    // sources 0..4 priorities 5,7,5,6,6
    src_cfg(16'h001F, 48'h6D7D);
    chk("source_priority_regs", 48'h6D7D, prio);
    chk("source_enable_regs", 16'h001F, en);
    pulse(16'h0004, 16'h0000);
    chk("pending", 16'h0004, pend);
    expect_req(12'h0A5);
    chk("level after ack", 4'h5, level);
    chk("cpu_status_reg", 8'hA0, status);
    chk("pending kept", 16'h0004, pend);
    // equal priority to the level is refused
    pulse(16'h0001, 16'h0000);
    no_req(6);
    ack_delay <= 4'h3;
    pulse(16'h0002, 16'h0000);
    expect_req(12'h097);
    pulse(16'h0000, 16'hFFFF);
    chk("pending cleared", 16'h0000, pend);
    wr(4, 16'h0060);
    chk("status write", {8'h60, 4'h3}, {status, level});
    wr(4, 16'h0000);
    // global enable off blocks, then tie between 3 and 4
    wr(1, 16'h0000);
    chk("gcb", 16'h0000, gcb);
    pulse(16'h0018, 16'h0000);
    no_req(6);
    wr(1, 16'h8000);
    expect_req(12'h0B6);
    chk("level tie", 4'h6, level);
    pulse(16'h0000, 16'hFFFF);
    wr(4, 16'h0000);
    src_cfg(16'h0017, 48'h6D7D);
    pulse(16'h0008, 16'h0000);
    chk("pending disabled", 16'h0008, pend);
    no_req(6);
    // external line zero, rising edge, lands on source 0
    @(posedge clk);
    ext_pin <= 1'b1;
    repeat (4) @(posedge clk);
    ext_pin <= 1'b0;
    expect_req(12'h085);
    chk("ext pending", 16'h0009, pend);
    // falling polarity: a rise is ignored, the fall requests
    pulse(16'h0000, 16'hFFFF);
    wr(4, 16'h0000);
    wr(1, 16'h8001);
    @(posedge clk);
    ext_pin <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk("ext rise ignored", 16'h0000, pend);
    @(posedge clk);
    ext_pin <= 1'b0;
    expect_req(12'h085);
    // trap flags
    @(posedge clk);
    {trap_event, dma_trap_event, loop_trap_event, soft_trap_event} <= {5'h15, 3'b111};
    @(posedge clk);
    {trap_event, dma_trap_event, loop_trap_event, soft_trap_event} <= '0;
    #1;
    chk("gca traps", 16'h0015, gca);
    chk("gcc traps", 16'h0030, gcc);
    chk("gcd trap", 16'h0001, gcd);
    wr(0, 16'h8015);
    chk("gca nesting", 16'h8000, gca);
    wr(2, 16'h0000);
    chk("gcc cleared", 16'h0000, gcc);
    wr(3, 16'h0000);
    chk("gcd cleared", 16'h0000, gcd);
    // core-owned level bit cannot be written through the status word
    @(posedge clk);
    msb_set <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("core_control_reg", 16'h0008, core_ctrl);
    chk("level msb", 1, level[3]);
    wr(4, 16'h0000);
    chk("level msb kept", 1, level[3]);
    summarize();
  end
endmodule : testbench
